// >>> logic/rbcl_pkg.sv
// Operation
// (R01) Start a load on boot_initiate fall, power-up, or configuration reset release.
// (R02) Configuration reset held high clears memory; its release starts configuration.
// (R03) Each load first clears the whole configuration memory for a size-dependent time.
// (R04) memory_enable_n goes low at load start and stays low throughout loading.
// (R05) Data sampled two clocks after enable falls, then every second clock.
// (R06) All sequencing runs from the single configuration clock, internal or external; restarts and the address follow after done run on ref_clk without it.
// (R07) Clock pin outputs internal clock when mode bit 2 low, else is input.
// (R08) Strobe tristated until one clock before enable; each pulse means latched, advance.
// (R09) External address generator advances on every strobe rising edge, from the first.
// (R10) Address outputs used only in internal byte mode; serial mode reads bit 0.
// (R11) Internal byte mode drives an 18-bit address and reads eight-bit data.
// (R12) Address tristated during clear, driven while loading, released at user mode.
// (R13) First address appears with enable fall; address increments on each strobe rise.
// (R14) After a verified row, hold address and strobe high during the row write.
// (R15) Every row write lasts twelve configuration clocks with strobe held high.
// (R16) On completion assert done, tristate strobe; inputs and enable off +2, outputs +3.
// (R17) User mode three clocks after power-up, or after done if power-up already high.
// (R18) Error output on check byte or identifier mismatch, two clocks after the byte.
// (R19) After an error loading halts until a new boot edge, reset or power cycle.
// (R20) After done the strobe is an input; address follows it until power-up.
// (R21) Single-device boards pull the strobe pin high weakly once it is an input.
// (R22) Mode 01 byte internal address, 10 serial, 11 byte external address.
package rbcl_pkg;
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam logic [1:0] CFG_DIV_LAST = 2'h3;  // Internal config clock is ref_clk / 4.
  localparam logic [11:0] CLEAR_CLKS = 12'h3CB;  // 971 clocks of memory clear.
  localparam logic [7:0] ROW_COUNT = 8'h5F;  // 95 rows.
  localparam logic [7:0] ROW_BYTES = 8'h48;  // 72 data bytes per row.
  localparam logic [7:0] ID_BYTES = 8'h04;
  localparam logic [11:0] ROW_WRITE_CLKS = 12'h00C;  // 12 clocks.
  localparam logic [11:0] ERR_DELAY_CLKS = 12'h002;
  localparam logic [11:0] DONE_TO_IN_CLKS = 12'h002;
  localparam logic [11:0] DONE_TO_OUT_CLKS = 12'h003;
  localparam logic [31:0] DEVICE_ID = 32'h5A3C_96E1;  // Arbitrary value.
  localparam logic [1:0] MODE_BYTE_INT = 2'h1;
  localparam logic [1:0] MODE_SERIAL = 2'h2;
  localparam logic [1:0] MODE_BYTE_EXT = 2'h3;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_ADDR = 4'h8;
  localparam logic [3:0] REG_ROWS = 4'hC;
  localparam logic [17:0] ADDR_RESET = 18'h00000;

  typedef enum logic [3:0] {
    ST_IDLE, ST_CLEAR, ST_PRE, ST_LOAD, ST_ROW, ST_ERRW, ST_ERR, ST_DONE, ST_USER
  } rbcl_state_e;

  // Status word as software sees it.
  typedef struct packed {
    logic [3:0] state;
    logic user_out;
    logic user_in;
    logic done;
    logic err;
  } rbcl_status_s;
endpackage

// >>> logic/rbcl_loader.sv
`timescale 1ns/1ns
`default_nettype none
module rbcl_loader
  import rbcl_pkg::*;
(
  input wire logic ref_clk,  // Configuration logic clock.
  input wire logic srst,  // Synchronous reset, acts as power-up.
  input wire logic [2:0] mode_pins,  // Mode pins 2..0.
  input wire logic cfg_reset,  // Configuration reset pin, high clears.
  input wire logic boot_initiate,  // Falling edge starts a load.
  input wire logic power_up_release,  // High lets user mode begin.
  input wire logic clk_pin_i,  // Clock pin level when used as input.
  output logic clk_pin_o,  // Internal configuration clock out.
  output logic clk_pin_oe,  // Clock pin drive enable.
  input wire logic [7:0] data_i,  // Configuration memory data.
  input wire logic data_strobe_i,  // Strobe pin level when released.
  output logic data_strobe_o,  // Data strobe drive value.
  output logic data_strobe_oe,  // Data strobe drive enable.
  output logic memory_enable_n,  // Memory enable, low while loading.
  output logic [17:0] addr_o,  // Memory address.
  output logic addr_oe,  // Address drive enable.
  output logic err_o,  // Open-drain error value, always low.
  output logic err_oe,  // High pulls the error pin low.
  output logic done,  // Configuration complete.
  output logic user_in_en,  // User inputs enabled.
  output logic user_out_en,  // User outputs enabled.
  output logic mem_clear,  // Configuration memory being cleared.
  output logic byte_valid,  // One-cycle strobe with row data byte.
  output logic [7:0] byte_data,  // Row data byte.
  output logic row_write,  // One-cycle pulse: write current row.
  output logic [7:0] row_index,  // Row being loaded.
  input wire logic [3:0] avs_address,  // Avalon byte address.
  input wire logic avs_read,  // Avalon read.
  input wire logic avs_write,  // Avalon write.
  input wire logic [31:0] avs_writedata,  // Avalon write data.
  output logic [31:0] avs_readdata,  // Avalon read data.
  output logic avs_waitrequest  // Avalon wait request.
);
  // Pin inputs pass two flip-flops; only stage two and its delayed copy feed logic.
  // Bit map: data 7:0, mode 10:8, power-up 11, boot 12, reset 13, clock 14, strobe 15.
  logic [15:0] pin_s1;
  logic [15:0] pin_s2;
  logic [3:0] pin_s3;
  logic boot_fall;
  logic rst_rise;
  logic rst_fall;
  logic ext_rise;
  logic strobe_rise;
  logic tick;
  logic soft_boot;
  logic start;
  logic [1:0] div_cnt;
  logic [1:0] next_div_cnt;
  logic next_clk_pin_o;
  rbcl_state_e state;
  rbcl_state_e next_state;
  logic [11:0] cnt;
  logic [11:0] next_cnt;
  logic [1:0] mode_q;
  logic [1:0] next_mode_q;
  logic [7:0] idx;
  logic [7:0] next_idx;
  logic [2:0] bit_idx;
  logic [2:0] next_bit_idx;
  logic [7:0] shift;
  logic [7:0] next_shift;
  logic [7:0] csum;
  logic [7:0] next_csum;
  logic in_id;
  logic next_in_id;
  logic [7:0] got;
  logic got_ok;
  logic next_strobe_o;
  logic next_strobe_oe;
  logic next_me_n;
  logic [17:0] next_addr;
  logic next_addr_oe;
  logic next_err_oe;
  logic next_done;
  logic next_user_in;
  logic next_user_out;
  logic next_clear;
  logic next_bvalid;
  logic [7:0] next_bdata;
  logic next_row_write;
  logic [7:0] next_row;
  logic next_wait;
  logic [31:0] next_rdata;
  rbcl_status_s status;

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      pin_s1 <= 16'h0000;
      pin_s2 <= 16'h0000;
      pin_s3 <= 4'h0;
    end
    else
    begin
      pin_s1 <= {data_strobe_i, clk_pin_i, cfg_reset, boot_initiate, power_up_release,
                 mode_pins, data_i};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2[15:12];
    end
  end

  // Edge detectors look at stage two and its delayed copy only.
  assign boot_fall = pin_s3[0] & ~pin_s2[12];  // R01
  assign rst_rise = ~pin_s3[1] & pin_s2[13];
  assign rst_fall = pin_s3[1] & ~pin_s2[13];
  assign ext_rise = ~pin_s3[2] & pin_s2[14];
  assign strobe_rise = ~pin_s3[3] & pin_s2[15];
  // Mode bit 2 picks the clock source; both feed the same enable, one process.
  assign tick = pin_s2[10] ? ext_rise : (div_cnt == CFG_DIV_LAST);  // R06 R07
  assign soft_boot = avs_write & ~avs_waitrequest & (avs_address == REG_CTRL) & avs_writedata[0];
  assign start = boot_fall | rst_fall | soft_boot;  // R01 R02

  // Divider for the internal configuration clock; it runs even when unused.
  always_comb
  begin
    next_div_cnt = div_cnt + 2'h1;
    next_clk_pin_o = (next_div_cnt < 2'h2);
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      div_cnt <= 2'h0;
      clk_pin_o <= 1'b0;
      clk_pin_oe <= 1'b0;
    end
    else
    begin
      div_cnt <= next_div_cnt;
      clk_pin_o <= next_clk_pin_o;
      clk_pin_oe <= ~pin_s2[10];  // R07
    end
  end

  // Byte assembled from this sample: serial mode takes bit 0 only, LSB first.
  assign got = (mode_q == MODE_SERIAL) ? {pin_s2[0], shift[7:1]} : pin_s2[7:0];  // R10
  assign got_ok = (mode_q != MODE_SERIAL) | (bit_idx == 3'h7);

  // Load sequencer; each step waits for a configuration clock enable, except restarts and the address follow after done.
  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    next_mode_q = mode_q;
    next_idx = idx;
    next_bit_idx = bit_idx;
    next_shift = shift;
    next_csum = csum;
    next_in_id = in_id;
    next_strobe_o = data_strobe_o;
    next_strobe_oe = data_strobe_oe;
    next_me_n = memory_enable_n;
    next_addr = addr_o;
    next_addr_oe = addr_oe;
    next_err_oe = err_oe;
    next_done = done;
    next_user_in = user_in_en;
    next_user_out = user_out_en;
    next_clear = mem_clear;
    next_bvalid = 1'b0;
    next_bdata = byte_data;
    next_row_write = 1'b0;
    next_row = row_index;
    // The mode is taken when clearing begins, including the power-up clear.
    if (state == ST_CLEAR && cnt == 12'h000)
    begin
      next_mode_q = pin_s2[9:8];  // R22
    end
    if (start || pin_s2[13] || rst_rise)
    begin
      // A restart drops every sequencer output except byte_data back to the clearing state.
      next_state = ST_CLEAR;  // R02 R03 R19
      next_cnt = 12'h000;
      next_mode_q = pin_s2[9:8];
      next_strobe_oe = 1'b0;
      next_strobe_o = 1'b0;
      next_me_n = 1'b1;
      next_addr = ADDR_RESET;
      next_addr_oe = 1'b0;  // R12
      next_err_oe = 1'b0;
      next_done = 1'b0;
      next_user_in = 1'b0;
      next_user_out = 1'b0;
      next_clear = 1'b1;
      next_row = 8'h00;
    end
    else if (state == ST_DONE && strobe_rise && !pin_s2[11])
    begin
      next_addr = addr_o + 18'h00001;  // R20
    end
    else if (tick)
    begin
      unique case (state)
        ST_IDLE, ST_USER, ST_ERR:
        begin
          next_state = state;  // R19
        end
        ST_CLEAR:
        begin
          if (cnt == CLEAR_CLKS - 12'h001)
          begin
            next_state = ST_PRE;
            next_clear = 1'b0;
            next_strobe_oe = 1'b1;  // R08
            next_strobe_o = 1'b1;
          end
          else
          begin
            next_cnt = cnt + 12'h001;  // R03
          end
        end
        ST_PRE:
        begin
          next_state = ST_LOAD;
          next_me_n = 1'b0;  // R04
          next_addr_oe = (mode_q == MODE_BYTE_INT);  // R10 R11 R12 R13 R22
          next_in_id = 1'b1;
          next_idx = 8'h00;
          next_bit_idx = 3'h0;
          next_csum = 8'h00;
        end
        ST_LOAD:
        begin
          next_strobe_o = ~data_strobe_o;  // R05
          if (!data_strobe_o)
          begin
            // Sample on the rising strobe edge, then advance the address.
            next_addr = addr_o + 18'h00001;  // R13
            next_shift = got;
            next_bit_idx = bit_idx + 3'h1;
            if (got_ok && in_id)
            begin
              if (got != DEVICE_ID[idx[1:0] * 8 +: 8])
              begin
                next_state = ST_ERRW;  // R18
                next_cnt = 12'h000;
              end
              next_idx = (idx == ID_BYTES - 8'h01) ? 8'h00 : idx + 8'h01;
              next_in_id = (idx != ID_BYTES - 8'h01);
            end
            else if (got_ok && idx != ROW_BYTES)
            begin
              next_csum = csum ^ got;
              next_bvalid = 1'b1;
              next_bdata = got;
              next_idx = idx + 8'h01;
            end
            else if (got_ok && got == csum)
            begin
              next_state = ST_ROW;  // R14
              next_cnt = 12'h000;
              next_row_write = 1'b1;
              next_addr = addr_o;  // R14
              next_idx = 8'h00;
              next_csum = 8'h00;
            end
            else if (got_ok)
            begin
              next_state = ST_ERRW;  // R18
              next_cnt = 12'h000;
            end
          end
        end
        ST_ROW:
        begin
          next_addr = addr_o + 18'h00001;
          if (cnt == ROW_WRITE_CLKS - 12'h001)  // R15
          begin
            next_row = row_index + 8'h01;
            if (row_index == ROW_COUNT - 8'h01)
            begin
              next_state = ST_DONE;
              next_done = 1'b1;  // R16
              next_strobe_oe = 1'b0;  // R16 R20
              next_cnt = 12'h000;
            end
            else
            begin
              next_state = ST_LOAD;
            end
          end
          else
          begin
            next_addr = addr_o;  // R14
            next_cnt = cnt + 12'h001;
          end
        end
        ST_ERRW:
        begin
          if (cnt == ERR_DELAY_CLKS - 12'h001)
          begin
            next_state = ST_ERR;
            next_err_oe = 1'b1;  // R18
            next_strobe_oe = 1'b0;
            next_me_n = 1'b1;
          end
          else
          begin
            next_cnt = cnt + 12'h001;
          end
        end
        ST_DONE:
        begin
          // Count runs only once power-up is seen, so a late power-up still gives 2 and 3.
          if (pin_s2[11])
          begin
            next_cnt = cnt + 12'h001;  // R17
            if (cnt == DONE_TO_IN_CLKS - 12'h001)
            begin
              next_user_in = 1'b1;  // R16
              next_me_n = 1'b1;
            end
            if (cnt == DONE_TO_OUT_CLKS - 12'h001)
            begin
              next_user_out = 1'b1;  // R16 R17
              next_addr_oe = 1'b0;  // R12
              next_state = ST_USER;
            end
          end
        end
        default:
        begin
          next_state = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      // Power-up behaves as a boot request: clearing starts at once.
      state <= ST_CLEAR;  // R01
      cnt <= 12'h000;
      mode_q <= MODE_BYTE_INT;
      idx <= 8'h00;
      bit_idx <= 3'h0;
      shift <= 8'h00;
      csum <= 8'h00;
      in_id <= 1'b0;
      data_strobe_o <= 1'b0;
      data_strobe_oe <= 1'b0;
      memory_enable_n <= 1'b1;
      addr_o <= ADDR_RESET;
      addr_oe <= 1'b0;
      err_o <= 1'b0;
      err_oe <= 1'b0;
      done <= 1'b0;
      user_in_en <= 1'b0;
      user_out_en <= 1'b0;
      mem_clear <= 1'b1;
      byte_valid <= 1'b0;
      byte_data <= 8'h00;
      row_write <= 1'b0;
      row_index <= 8'h00;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      mode_q <= next_mode_q;
      idx <= next_idx;
      bit_idx <= next_bit_idx;
      shift <= next_shift;
      csum <= next_csum;
      in_id <= next_in_id;
      data_strobe_o <= next_strobe_o;
      data_strobe_oe <= next_strobe_oe;
      memory_enable_n <= next_me_n;
      addr_o <= next_addr;
      addr_oe <= next_addr_oe;
      err_o <= 1'b0;
      err_oe <= next_err_oe;
      done <= next_done;
      user_in_en <= next_user_in;
      user_out_en <= next_user_out;
      mem_clear <= next_clear;
      byte_valid <= next_bvalid;
      byte_data <= next_bdata;
      row_write <= next_row_write;
      row_index <= next_row;
    end
  end

  // Register slave: one wait cycle, so every access ends on the second edge.
  always_comb
  begin
    status = '{state: state, user_out: user_out_en, user_in: user_in_en, done: done,
               err: err_oe};
    next_wait = ~((avs_read | avs_write) & avs_waitrequest);
    next_rdata = avs_readdata;
    if (avs_read && avs_waitrequest)
    begin
      unique case (avs_address)
        REG_STATUS: next_rdata = {24'h000000, status};
        REG_ADDR: next_rdata = {14'h0000, addr_o};
        REG_ROWS: next_rdata = {24'h000000, row_index};
        default: next_rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end
    else
    begin
      avs_waitrequest <= next_wait;
      avs_readdata <= next_rdata;
    end
  end

  // Ticks spent in row write, checked against the fixed row write length.
  logic [11:0] row_ticks;
  always_ff @(posedge ref_clk)
  begin
    if (srst || state != ST_ROW)
      row_ticks <= 12'h000;
    else if (tick)
      row_ticks <= row_ticks + 12'h001;
  end

  property p_me_low;
    @(posedge ref_clk) disable iff (srst) (state == ST_LOAD || state == ST_ROW) |-> !memory_enable_n;
  endproperty
  a_me_low: assert property (p_me_low) else $error("Enable high during load."); // R04
  property p_clear_float;
    @(posedge ref_clk) disable iff (srst) state == ST_CLEAR |-> !data_strobe_oe && !addr_oe;
  endproperty
  a_clear_float: assert property (p_clear_float) else $error("Pin driven in clear."); // R08
  property p_user_rel;
    @(posedge ref_clk) disable iff (srst) state == ST_USER |-> !addr_oe && user_out_en;
  endproperty
  a_user_rel: assert property (p_user_rel) else $error("Address kept in user."); // R12
  property p_row_hold;
    @(posedge ref_clk) disable iff (srst)
      state == ST_ROW && $past(state) == ST_ROW |-> data_strobe_o && $stable(addr_o);
  endproperty
  a_row_hold: assert property (p_row_hold) else $error("Row write not held."); // R14
  property p_row_len;
    @(posedge ref_clk) disable iff (srst)
      $fell(state == ST_ROW) && state != ST_CLEAR |-> $past(row_ticks) == 12'h00B;
  endproperty
  a_row_len: assert property (p_row_len) else $error("Row write length wrong."); // R15
  property p_err_src;
    @(posedge ref_clk) disable iff (srst) $rose(err_oe) |-> $past(state) == ST_ERRW && !err_o;
  endproperty
  a_err_src: assert property (p_err_src) else $error("Error without cause."); // R18
  property p_err_halt;
    @(posedge ref_clk) disable iff (srst)
      state == ST_ERR && !start && !pin_s2[13] ##1 !start |-> state == ST_ERR;
  endproperty
  a_err_halt: assert property (p_err_halt) else $error("Load resumed after error."); // R19
  property p_addr_mode;
    @(posedge ref_clk) disable iff (srst) addr_oe |-> mode_q == MODE_BYTE_INT;
  endproperty
  a_addr_mode: assert property (p_addr_mode) else $error("Address driven in wrong mode."); // R10
  property p_done_float;
    @(posedge ref_clk) disable iff (srst) $rose(done) |-> !data_strobe_oe && !user_in_en;
  endproperty
  a_done_float: assert property (p_done_float) else $error("Strobe driven at done."); // R16
  property p_addr_inc;
    @(posedge ref_clk) disable iff (srst)
      $rose(data_strobe_o) && $past(state) == ST_LOAD && state == ST_LOAD
      |-> addr_o == $past(addr_o) + 18'h00001;
  endproperty
  a_addr_inc: assert property (p_addr_inc) else $error("Address did not advance."); // R13
  c_user: cover property (@(posedge ref_clk) disable iff (srst) $rose(user_out_en));
  c_err: cover property (@(posedge ref_clk) disable iff (srst) $rose(err_oe));
  c_row: cover property (@(posedge ref_clk) disable iff (srst) row_write);
  c_restart: cover property (@(posedge ref_clk) disable iff (srst) state == ST_LOAD && start);
endmodule
`default_nettype wire

// >>> test/rbcl_cfg_mem.sv
`timescale 1ns/1ns
`default_nettype none
// Behavioural configuration memory that answers by address or by counting strobe rises.
module rbcl_cfg_mem
  import rbcl_pkg::*;
(
  input wire logic ref_clk,  // Bench clock.
  input wire logic [1:0] mode,  // Mode given to the loader.
  input wire logic slow,  // Adds three cycles of read lag.
  input wire logic memory_enable_n,  // Low enables and runs the memory.
  input wire logic strobe,  // Resolved strobe pin level.
  input wire logic [17:0] addr,  // Address from the loader.
  output logic [7:0] data  // Data pins.
);
  logic [7:0] image [0:6938];
  logic [20:0] cnt = 21'h0;
  logic strobe_q = 1'b1;
  logic [7:0] junk = 8'h00;
  logic [7:0] p0, p1, p2, now;
  // The counter resets while disabled, so the first strobe rise moves it off zero.
  always_ff @(posedge ref_clk)
  begin
    strobe_q <= strobe;
    junk <= junk + 8'h35;
    p0 <= now;
    p1 <= p0;
    p2 <= p1;
    if (memory_enable_n)
      cnt <= 21'h0;
    else if (strobe && !strobe_q)
      cnt <= cnt + 21'h1;
  end
  // A disabled memory floats, so it shows a changing pattern, never the last byte.
  always_comb
  begin
    if (memory_enable_n)
      now = ~junk;
    else if (mode == MODE_SERIAL)
      now = {junk[7:1], image[cnt[20:3]][cnt[2:0]]};
    else if (mode == MODE_BYTE_INT)
      now = image[addr];
    else
      now = image[cnt[17:0]];
  end
  assign data = slow ? p2 : now;
endmodule
`default_nettype wire

// >>> test/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import rbcl_pkg::*;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic [2:0] mode_pins = 3'h1;
  logic cfg_reset = 1'b0;
  logic boot_initiate = 1'b0;
  logic power_up_release = 1'b0;
  logic clk_pin_i = 1'b0;
  logic ext_run = 1'b0;
  logic [1:0] ext_div = 2'h0;
  logic slow = 1'b0;
  logic chain_pull = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic clk_pin_o, clk_pin_oe, data_strobe_o, data_strobe_oe, memory_enable_n, addr_oe;
  logic err_o, err_oe, done, user_in_en, user_out_en, mem_clear, byte_valid, row_write;
  logic avs_waitrequest;
  logic [17:0] addr_o, a0;
  logic [7:0] byte_data, row_index;
  logic [31:0] avs_readdata;
  logic [7:0] exp_q [$];
  logic [31:0] rd_q [$];
  int fails = 0;
  int check_count = 0;
  int rows = 0;
  int n;
  wire logic [7:0] mem_data;
  wire logic strobe_pin;
  wire logic clk_pin;
  // Weak pull-up on the strobe pin; a chained neighbour may pull it low.
  assign strobe_pin = data_strobe_oe ? data_strobe_o : !chain_pull;
  assign clk_pin = clk_pin_oe ? clk_pin_o : clk_pin_i;
  rbcl_loader i_rbcl_loader (.ref_clk(ref_clk), .srst(srst), .mode_pins(mode_pins),
    .cfg_reset(cfg_reset), .boot_initiate(boot_initiate),
    .power_up_release(power_up_release), .clk_pin_i(clk_pin), .clk_pin_o(clk_pin_o),
    .clk_pin_oe(clk_pin_oe), .data_i(mem_data), .data_strobe_i(strobe_pin),
    .data_strobe_o(data_strobe_o), .data_strobe_oe(data_strobe_oe),
    .memory_enable_n(memory_enable_n), .addr_o(addr_o), .addr_oe(addr_oe), .err_o(err_o),
    .err_oe(err_oe), .done(done), .user_in_en(user_in_en), .user_out_en(user_out_en),
    .mem_clear(mem_clear), .byte_valid(byte_valid), .byte_data(byte_data),
    .row_write(row_write), .row_index(row_index), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  rbcl_cfg_mem i_rbcl_cfg_mem (.ref_clk(ref_clk), .mode(mode_pins[1:0]), .slow(slow),
    .memory_enable_n(memory_enable_n), .strobe(strobe_pin), .addr(addr_o), .data(mem_data));
  // Main clock, and an external configuration clock at one sixth of its rate.
  initial
  begin
    forever #4 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    ext_div <= (ext_div == 2'h2) ? 2'h0 : ext_div + 2'h1;
    if (ext_run && ext_div == 2'h2)
      clk_pin_i <= ~clk_pin_i;
  end
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One bus access, held until waitrequest is sampled low, then released.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0 && k < 50)
    begin
      @(posedge ref_clk);
      k++;
    end
    if (k == 50)
      chk("waitrequest", 0, 1);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    rd_q.push_back(exp);
    bus(1'b0, a, 32'h0);
  endtask
  function automatic logic pick(input int w);
    case (w)
      0: return err_oe;
      1: return done;
      2: return mem_clear;
      3: return !memory_enable_n;
      default: return user_in_en;
    endcase
  endfunction
  task automatic wait_for(input int w, input int lim);
    n = 0;
    while (pick(w) !== 1'b1 && n < lim)
    begin
      @(posedge ref_clk);
      n++;
    end
    chk("awaited output", 1, pick(w));
  endtask
  // Image: identifier, then rows of 72 random bytes and their XOR check byte.
  task automatic fill(input int bad);
    logic [7:0] x;
    for (int b = 0; b < 4; b++)
      i_rbcl_cfg_mem.image[b] = DEVICE_ID[8*b +: 8];
    for (int r = 0; r < 95; r++)
    begin
      x = 8'h00;
      for (int k = 0; k < 72; k++)
      begin
        i_rbcl_cfg_mem.image[4 + r * 73 + k] = 8'($urandom);
        x ^= i_rbcl_cfg_mem.image[4 + r * 73 + k];
      end
      i_rbcl_cfg_mem.image[4 + r * 73 + 72] = x;
    end
    if (bad == 1)
      i_rbcl_cfg_mem.image[1] = ~DEVICE_ID[15:8];
    if (bad == 2)
      i_rbcl_cfg_mem.image[76] = ~i_rbcl_cfg_mem.image[76];
  endtask
  task automatic push_rows(input int nr);
    for (int r = 0; r < nr; r++)
      for (int k = 0; k < 72; k++)
        exp_q.push_back(i_rbcl_cfg_mem.image[4 + r * 73 + k]);
  endtask
  task automatic boot();
    boot_initiate <= 1'b1;
    repeat (12) @(posedge ref_clk);
    boot_initiate <= 1'b0;
    wait_for(2, 60);
  endtask
  // Watcher: each byte or read result that appears takes the oldest note off its queue; row pulses are counted.
  always @(posedge ref_clk)
  begin
    if (byte_valid === 1'b1)
      chk("byte_data", exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX, byte_data);
    if (row_write === 1'b1)
      rows++;
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && rd_q.size() > 0)
      chk("readdata", rd_q.pop_front(), avs_readdata);
  end
  initial
  begin
    repeat (99000) @(posedge ref_clk);
    fails++;
    end_sim();
  end
  initial
  begin
    void'($urandom(76));
    fill(2);
    push_rows(1);
    repeat (20) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    rd(REG_STATUS, 32'h10);
    rd(REG_CTRL, 32'h0);
    bus(1'b1, 4'h2, 32'hFFFF_FFFF);
    rd(4'h2, 32'h0);
    chk("addr_oe in clear", 0, addr_oe);
    chk("strobe oe in clear", 0, data_strobe_oe);
    chk("clk_pin_oe", 1, clk_pin_oe);
    wait_for(0, 9000);
    repeat (300) @(posedge ref_clk);
    chk("enable after error", 1, memory_enable_n);
    rd(REG_STATUS, 32'h61);
    chk("bytes left", 0, 32'(exp_q.size()));
    fill(0);
    push_rows(95);
    slow <= 1'b1;
    boot();
    rd(REG_STATUS, 32'h10);
    wait_for(3, 5000);
    chk("first address", 0, 32'(addr_o));
    chk("addr_oe loading", 1, addr_oe);
    wait_for(1, 70000);
    chk("rows written", 95, rows);
    chk("bytes left", 0, 32'(exp_q.size()));
    chk("strobe oe done", 0, data_strobe_oe);
    chk("user inputs early", 0, user_in_en);
    a0 = addr_o;
    repeat (3)
    begin
      repeat (8) @(posedge ref_clk);
      chain_pull <= 1'b1;
      repeat (8) @(posedge ref_clk);
      chain_pull <= 1'b0;
    end
    repeat (12) @(posedge ref_clk);
    chk("chained address", 32'(a0 + 18'h3), 32'(addr_o));
    power_up_release <= 1'b1;
    wait_for(4, 60);
    chk("enable at user inputs", 1, memory_enable_n);
    n = 0;
    while (user_out_en !== 1'b1 && n < 20)
    begin
      @(posedge ref_clk);
      n++;
    end
    chk("inputs to outputs", 4, n);
    chk("addr_oe user", 0, addr_oe);
    mode_pins <= 3'h3;
    fill(1);
    cfg_reset <= 1'b1;
    repeat (20) @(posedge ref_clk);
    chk("clear under reset", 1, mem_clear);
    cfg_reset <= 1'b0;
    wait_for(0, 6000);
    chk("addr_oe external", 0, addr_oe);
    slow <= 1'b0;
    mode_pins <= 3'h6;
    ext_run <= 1'b1;
    fill(2);
    push_rows(1);
    boot();
    chk("clk_pin_oe external", 0, clk_pin_oe);
    wait_for(0, 16000);
    chk("serial bytes left", 0, 32'(exp_q.size()));
    bus(1'b1, REG_CTRL, 32'h1);
    wait_for(2, 60);
    chk("error cleared", 0, err_oe);
    rd(REG_STATUS, 32'h10);
    end_sim();
  end
endmodule
`default_nettype wire
